// ==== hdl/port_gate_defs.svh ====
`ifndef PORT_GATE_DEFS_SVH
`define PORT_GATE_DEFS_SVH
// Overview of operation
// - A port whose enable bit is 1 in the register for the current power mode receives its clock.
// - A port whose enable bit is 0 in that register has its clock stopped and is held disabled.
// - A read or write aimed at a port whose clock is gated off ends in a bus fault.
// - After reset every port enable bit of both low-power gating registers reads 0.
// - Running uses the run gating register, Sleep the sleep one, Deep-Sleep the deep-sleep one.
// - The sleep and deep-sleep registers apply only while the automatic-gating select bit is set.
// - Bits 4 down to 0 of each gating register gate ports E, D, C, B and A, one bit per port.
// - The sleep gating register sits at offset 0x118 and resets to 0x00000000.
// - The deep-sleep gating register sits at offset 0x128 with the same layout.
// - Both gating registers reset to all zeros and their port fields are read-write.

// Register byte offsets.
`define RUN_CFG_OFS 12'h060
`define RUN_GATE_OFS 12'h108
`define SLEEP_GATE_OFS 12'h118
`define DEEP_GATE_OFS 12'h128
`define IRQ_STATUS_OFS 12'h200
`define IRQ_MASK_OFS 12'h204
`define GATE_STATE_OFS 12'h208
`define FAULT_COUNT_OFS 12'h20C

// Field positions.
`define PORT_FIELD_MSB 4
`define AUTO_GATE_BIT 0
`define STATE_MODE_LSB 8
`define STATE_MODE_MSB 10

// Reset values.
`define GATE_RESET 32'h00000000
`define RUN_CFG_RESET 32'h00000000
`define IRQ_MASK_RESET 32'h00000000

// Timing: a register access answers with PREADY one cycle after the access phase starts.
`define APB_WAIT_CYCLES 1
`endif

// ==== hdl/port_gate_pkg.sv ====
package port_gate_pkg;
    typedef logic [4:0] port_vec_t;
    typedef enum logic [2:0] {
        PM_RUN = 3'b001,
        PM_SLEEP = 3'b010,
        PM_DEEP = 3'b100
    } power_mode_t;
    typedef enum logic [1:0] {
        AS_IDLE = 2'b01,
        AS_DONE = 2'b10
    } apb_state_t;
endpackage

// ==== hdl/gate_if.sv ====
`timescale 1ns/1ps
interface gate_if;
    import port_gate_pkg::*;
    port_vec_t run_en;
    port_vec_t sleep_en;
    port_vec_t deep_en;
    logic auto_sel;
    power_mode_t mode;
    port_vec_t port_req;
    port_vec_t active_en;
    port_vec_t fault_hit;
    port_vec_t grant_hit;
    modport ctrl (
        output run_en,
        output sleep_en,
        output deep_en,
        output auto_sel,
        output mode,
        output port_req,
        input active_en,
        input fault_hit,
        input grant_hit
    );
    modport sel (
        input run_en,
        input sleep_en,
        input deep_en,
        input auto_sel,
        input mode,
        input port_req,
        output active_en,
        output fault_hit,
        output grant_hit
    );
endinterface

// ==== hdl/gate_select.sv ====
`timescale 1ns/1ps
module gate_select (
    gate_if.sel gi
);
    import port_gate_pkg::*;

    port_vec_t chosen;

    // Without the select bit the low-power registers are ignored and run settings stay.
    always_comb begin
        chosen = gi.run_en;
        if (gi.auto_sel) begin
            case (gi.mode)
                PM_RUN: begin
                    chosen = gi.run_en;
                end
                PM_SLEEP: begin
                    chosen = gi.sleep_en;
                end
                PM_DEEP: begin
                    chosen = gi.deep_en;
                end
                default: begin
                    chosen = gi.run_en;
                end
            endcase
        end
    end

    assign gi.active_en = chosen;
    assign gi.fault_hit = gi.port_req & ~chosen;
    assign gi.grant_hit = gi.port_req & chosen;
endmodule // gate_select

// ==== hdl/port_gate.sv ====
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "port_gate_defs.svh"
module port_gate #(
    parameter int ADDR_W = 12,
    parameter int NUM_PORTS = 5,
    parameter int COUNT_W = 16
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST_B,
    // Register bus.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Power mode from the power controller.
    input wire port_gate_pkg::power_mode_t POWER_MODE,
    // Accesses aimed at the ports.
    input wire port_gate_pkg::port_vec_t PORT_REQ,
    output port_gate_pkg::port_vec_t PORT_FAULT,
    output port_gate_pkg::port_vec_t PORT_GRANT,
    // Port clock enables.
    output port_gate_pkg::port_vec_t PORT_CLK_EN,
    // Interrupt.
    output logic IRQ
);
    import port_gate_pkg::*;

    gate_if gi ();

    apb_state_t state_r;
    apb_state_t state_nxt;
    port_vec_t run_gate_r;
    port_vec_t sleep_gate_r;
    port_vec_t deep_gate_r;
    logic auto_sel_r;
    port_vec_t irq_status_r;
    port_vec_t irq_mask_r;
    logic [COUNT_W-1:0] fault_count_r;
    logic [COUNT_W-1:0] fault_count_nxt;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic pready_r;
    logic pslverr_r;
    port_vec_t clk_en_r;
    port_vec_t fault_r;
    port_vec_t grant_r;
    logic irq_r;

    // Address decode.
    wire access = PSEL && PENABLE;
    wire aligned = (PADDR[1:0] == 2'h0);
    wire [11:0] ofs = 12'(PADDR);
    wire hit_run_cfg = aligned && (ofs == `RUN_CFG_OFS);
    wire hit_run = aligned && (ofs == `RUN_GATE_OFS);
    wire hit_sleep = aligned && (ofs == `SLEEP_GATE_OFS);
    wire hit_deep = aligned && (ofs == `DEEP_GATE_OFS);
    wire hit_status = aligned && (ofs == `IRQ_STATUS_OFS);
    wire hit_mask = aligned && (ofs == `IRQ_MASK_OFS);
    wire hit_state = aligned && (ofs == `GATE_STATE_OFS);
    wire hit_count = aligned && (ofs == `FAULT_COUNT_OFS);
    wire mapped = hit_run_cfg || hit_run || hit_sleep || hit_deep || hit_status
        || hit_mask || hit_state || hit_count;

    // Writes commit at the edge where the master sees PREADY high.
    wire commit = access && (state_r == AS_DONE);
    wire wr_lane0 = commit && PWRITE && PSTRB[0];
    wire wr_run_cfg = wr_lane0 && hit_run_cfg;
    wire wr_run = wr_lane0 && hit_run;
    wire wr_sleep = wr_lane0 && hit_sleep;
    wire wr_deep = wr_lane0 && hit_deep;
    wire wr_status = wr_lane0 && hit_status;
    wire wr_mask = wr_lane0 && hit_mask;
    wire wr_count = wr_lane0 && hit_count;
    // Only bits 4:0 are stored, so the upper bits drop any written value.
    wire [4:0] wr_ports = PWDATA[`PORT_FIELD_MSB:0];

    // Selection and fault checking live in the selector.
    assign gi.run_en = run_gate_r;
    assign gi.sleep_en = sleep_gate_r;
    assign gi.deep_en = deep_gate_r;
    assign gi.auto_sel = auto_sel_r;
    assign gi.mode = POWER_MODE;
    assign gi.port_req = PORT_REQ;

    gate_select u_sel (
        .gi(gi.sel)
    );

    // Read data, upper bits of the gating registers read as zero.
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (hit_run_cfg) begin
            rdata_nxt[`AUTO_GATE_BIT] = auto_sel_r;
        end
        if (hit_run) begin
            rdata_nxt[`PORT_FIELD_MSB:0] = run_gate_r;
        end
        if (hit_sleep) begin
            rdata_nxt[`PORT_FIELD_MSB:0] = sleep_gate_r;
        end
        if (hit_deep) begin
            rdata_nxt[`PORT_FIELD_MSB:0] = deep_gate_r;
        end
        if (hit_status) begin
            rdata_nxt[`PORT_FIELD_MSB:0] = irq_status_r;
        end
        if (hit_mask) begin
            rdata_nxt[`PORT_FIELD_MSB:0] = irq_mask_r;
        end
        if (hit_state) begin
            rdata_nxt[`PORT_FIELD_MSB:0] = clk_en_r;
            rdata_nxt[`STATE_MODE_MSB:`STATE_MODE_LSB] = POWER_MODE;
        end
        if (hit_count) begin
            rdata_nxt[COUNT_W-1:0] = fault_count_r;
        end
    end

    // Bus handshake: one wait cycle, then PREADY for one cycle.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            AS_IDLE: begin
                if (access) begin
                    state_nxt = AS_DONE;
                end
            end
            AS_DONE: begin
                state_nxt = AS_IDLE;
            end
            default: begin
                state_nxt = AS_IDLE;
            end
        endcase
    end

    wire start = access && (state_r == AS_IDLE);

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            state_r <= AS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= start;
            pslverr_r <= start && !mapped;
            prdata_r <= (start && !PWRITE) ? rdata_nxt : 32'h00000000;
        end
    end

    // Gating registers, all cleared so every port starts unclocked.
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            run_gate_r <= 5'(`GATE_RESET);
            sleep_gate_r <= 5'(`GATE_RESET);
            deep_gate_r <= 5'(`GATE_RESET);
        end else begin
            if (wr_run) begin
                run_gate_r <= wr_ports;
            end
            if (wr_sleep) begin
                sleep_gate_r <= wr_ports;
            end
            if (wr_deep) begin
                deep_gate_r <= wr_ports;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            auto_sel_r <= 1'(`RUN_CFG_RESET);
            irq_mask_r <= 5'(`IRQ_MASK_RESET);
        end else begin
            if (wr_run_cfg) begin
                auto_sel_r <= PWDATA[`AUTO_GATE_BIT];
            end
            if (wr_mask) begin
                irq_mask_r <= wr_ports;
            end
        end
    end

    // Port clock enables and access answers, registered so outputs come from flops.
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            clk_en_r <= 5'h00;
            fault_r <= 5'h00;
            grant_r <= 5'h00;
        end else begin
            clk_en_r <= gi.active_en;
            fault_r <= gi.fault_hit;
            grant_r <= gi.grant_hit;
        end
    end

    // A fault in the same cycle as a write-one-to-clear keeps its bit set.
    genvar i;
    generate
        for (i = 0; i < NUM_PORTS; i++) begin : g_status
            wire set_bit = gi.fault_hit[i];
            wire clr_bit = wr_status && wr_ports[i];
            always_ff @(posedge MCLK) begin
                if (!RST_B) begin
                    irq_status_r[i] <= 1'b0;
                end else if (set_bit) begin
                    irq_status_r[i] <= 1'b1;
                end else if (clr_bit) begin
                    irq_status_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Fault counter saturates so a storm of faults cannot wrap it back to a small value.
    wire any_fault = |gi.fault_hit;
    wire count_full = &fault_count_r;
    always_comb begin
        fault_count_nxt = fault_count_r;
        if (any_fault) begin
            // A fault in the same cycle as the clearing write wins, even when saturated.
            if (!count_full) begin
                fault_count_nxt = fault_count_r + COUNT_W'(1);
            end
        end else if (wr_count) begin
            fault_count_nxt = '0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            fault_count_r <= '0;
        end else begin
            fault_count_r <= fault_count_nxt;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_status_r & irq_mask_r);
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PORT_CLK_EN = clk_en_r;
    assign PORT_FAULT = fault_r;
    assign PORT_GRANT = grant_r;
    assign IRQ = irq_r;
endmodule // port_gate

// ==== tb/port_gate_properties.sv ====
`timescale 1ns/1ps
module port_gate_properties
    import port_gate_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST_B,
    // Register bus.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Mode and ports.
    input wire power_mode_t POWER_MODE,
    input wire port_vec_t PORT_REQ,
    input wire port_vec_t PORT_FAULT,
    input wire port_vec_t PORT_GRANT,
    input wire port_vec_t PORT_CLK_EN
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence

    // The enables must not move around a request, or fault and grant are ambiguous.
    sequence s_req_steady;
        (PORT_REQ != 5'h00 && $stable(PORT_CLK_EN)) ##1 $stable(PORT_CLK_EN);
    endsequence

    a_ready_one_wait: assert property (s_access |=> PREADY ##1 !PREADY)
        else $error("register access did not answer after one wait state");
    a_fault_gated: assert property (s_req_steady |->
        PORT_FAULT == ($past(PORT_REQ) & ~PORT_CLK_EN)) else $error("port fault wrong");
    a_grant_clocked: assert property (s_req_steady |->
        PORT_GRANT == ($past(PORT_REQ) & PORT_CLK_EN)) else $error("port grant wrong");
    a_fault_grant_excl: assert property ((PORT_FAULT & PORT_GRANT) == 5'h00)
        else $error("fault and grant together");
    a_reset_gated: assert property ($rose(RST_B) |-> PORT_CLK_EN == 5'h00)
        else $error("port clocked right after reset");
    a_upper_zero: assert property (PREADY && !PWRITE && PADDR[7:0] inside {8'h18, 8'h28}
        && PADDR[11:8] == 4'h1 |-> PRDATA[31:5] == 27'h0) else $error("upper bits not zero");
    a_sleep_mapped: assert property (PREADY && PADDR == 12'h118 |-> !PSLVERR)
        else $error("sleep register refused");
    a_deep_mapped: assert property (PREADY && PADDR == 12'h128 |-> !PSLVERR)
        else $error("deep-sleep register refused");
    a_en_steady: assert property ((!PSEL && $stable(POWER_MODE))[*3] |=>
        $stable(PORT_CLK_EN)) else $error("enables changed without cause");
endmodule // port_gate_properties

bind port_gate port_gate_properties #(.ADDR_W(ADDR_W)) u_props (.MCLK(MCLK), .RST_B(RST_B),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .POWER_MODE(POWER_MODE), .PORT_REQ(PORT_REQ),
    .PORT_FAULT(PORT_FAULT), .PORT_GRANT(PORT_GRANT), .PORT_CLK_EN(PORT_CLK_EN));

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import port_gate_pkg::*;
    logic MCLK = 1'b0;
    logic RST_B = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h00000000;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    power_mode_t POWER_MODE = PM_RUN;
    port_vec_t PORT_REQ = 5'h00;
    port_vec_t PORT_FAULT;
    port_vec_t PORT_GRANT;
    port_vec_t PORT_CLK_EN;
    logic IRQ;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int n_tests = 0;

    always #2 MCLK = ~MCLK;

    port_gate dut (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hF), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .POWER_MODE(POWER_MODE), .PORT_REQ(PORT_REQ),
        .PORT_FAULT(PORT_FAULT), .PORT_GRANT(PORT_GRANT), .PORT_CLK_EN(PORT_CLK_EN), .IRQ(IRQ));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Outputs are read in the edge's active region, so the value seen is the sampled one.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= addr;
        PWDATA <= data;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask

    task automatic probe(input port_vec_t req, input port_vec_t en);
        PORT_REQ <= req;
        @(posedge MCLK);
        PORT_REQ <= 5'h00;
        @(posedge MCLK);
        chk("port_clk_en", 32'(en), 32'(PORT_CLK_EN));
        chk("port_fault", 32'(req & ~en), 32'(PORT_FAULT));
        chk("port_grant", 32'(req & en), 32'(PORT_GRANT));
    endtask

    task automatic t_reset();
        apb(1'b0, 12'h118, 32'h0);
        chk("sleep_reset", 32'h00000000, rd);
        apb(1'b0, 12'h128, 32'h0);
        chk("deep_reset", 32'h00000000, rd);
        chk("clk_en_reset", 32'h0, 32'(PORT_CLK_EN));
        $display("test reset done");
    endtask

    task automatic t_fields();
        apb(1'b1, 12'h118, 32'hFFFFFFFF);
        apb(1'b0, 12'h118, 32'h0);
        chk("sleep_rw", 32'h0000001F, rd);
        apb(1'b1, 12'h128, 32'hFFFFFFEA);
        apb(1'b0, 12'h128, 32'h0);
        chk("deep_rw", 32'h0000000A, rd);
        $display("test fields done");
    endtask

    task automatic t_modes();
        power_mode_t modes[3] = '{PM_RUN, PM_SLEEP, PM_DEEP};
        port_vec_t sel[3] = '{5'h11, 5'h1F, 5'h0A};
        apb(1'b1, 12'h108, 32'h00000011);
        for (int a = 0; a < 2; a++) begin
            apb(1'b1, 12'h060, 32'(a));
            for (int i = 0; i < 3; i++) begin
                POWER_MODE <= modes[i];
                repeat (3) @(posedge MCLK);
                probe(5'h1F, (a == 1) ? sel[i] : 5'h11);
            end
        end
        $display("test modes done");
    endtask

    task automatic t_irq();
        POWER_MODE <= PM_RUN;
        apb(1'b1, 12'h204, 32'h00000004);
        apb(1'b1, 12'h200, 32'h0000001F);
        probe(5'h02, 5'h11);
        apb(1'b0, 12'h200, 32'h0);
        chk("status_b", 32'h00000002, rd);
        chk("irq_masked", 32'h0, 32'(IRQ));
        probe(5'h04, 5'h11);
        @(posedge MCLK);
        chk("irq_set", 32'h1, 32'(IRQ));
        apb(1'b1, 12'h200, 32'h00000006);
        @(posedge MCLK);
        chk("irq_clear", 32'h0, 32'(IRQ));
        $display("test irq done");
    endtask

    task automatic t_bad();
        apb(1'b0, 12'h300, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, 12'h11C, 32'h0);
        apb(1'b0, 12'h118, 32'h0);
        chk("sleep_kept", 32'h0000001F, rd);
        // Run mode with the run register at 0x11: state shows enables and the mode code.
        apb(1'b0, 12'h208, 32'h0);
        chk("gate_state", 32'h00000111, rd);
        // Clear the fault counter, make one fault on port C, and expect a count of one.
        apb(1'b1, 12'h20C, 32'h0);
        probe(5'h04, 5'h11);
        apb(1'b0, 12'h20C, 32'h0);
        chk("fault_count", 32'h00000001, rd);
        $display("test unmapped done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge MCLK);
        RST_B <= 1'b1;
        @(posedge MCLK);
        t_reset();
        t_fields();
        t_modes();
        t_irq();
        t_bad();
        print_verdict();
    end

    // The whole sequence needs about 130 cycles; the 5000-cycle limit leaves ample margin.
    initial begin
        repeat (5000) @(posedge MCLK);
        failures++;
        print_verdict();
    end
endmodule // testbench
